// *** include/dhcs_regs.svh ***
// Register offsets, field positions, reset values and timing counts of
// the host command and status block of the disk controller.
// Assumes a 40 MHz bus clock and a 32-bit AHB-Lite register bus.
//
// Behaviour
// R01: Host fills the parameter registers before writing any command.
// R02: Host usually writes sector, size/drive/head, cylinder, then command.
// R03: Parameter registers read back the value last written.
// R04: Restore and seek move heads and keep their step rate as implied rate.
// R05: Head positioning moves no bytes through the data register.
// R06: Host waits for interrupt or idle, then checks the error flag.
// R07: Fastest step rate is 35 us; restore and seek each carry a rate.
// R08: Host restores slowly at power-up, then seeks fast to set the rate.
// R09: Busy flag, bit 7, is set on start and cleared when done.
// R10: Interrupt output rises each time the host must step in.
// R11: Error register is meaningful only while the error flag is set.
// R12: Every command completes the same way, error or not.
// R13: Error flag is bit 0 and corrected flag bit 2 of status.
// R14: Corrected flag reports a fixed correctable error.
// R15: Fatal error sets most severe error bit, error flag, interrupt, idle.
// R16: Command write starts the command and sets busy at once.
`ifndef DHCS_REGS_SVH
`define DHCS_REGS_SVH

`define DHCS_OFS_DATA 8'h00
`define DHCS_OFS_ERROR 8'h04
`define DHCS_OFS_SCNT 8'h08
`define DHCS_OFS_SNUM 8'h0C
`define DHCS_OFS_CYLL 8'h10
`define DHCS_OFS_CYLH 8'h14
`define DHCS_OFS_SDH 8'h18
`define DHCS_OFS_STAT 8'h1C
`define DHCS_OFS_ISTAT 8'h20
`define DHCS_OFS_IMASK 8'h24
`define DHCS_OFS_RATE 8'h28

`define DHCS_HSIZE_WORD 3'h2

`define DHCS_ST_BUSY 7
`define DHCS_ST_CORR 2
`define DHCS_ST_ERR 0

`define DHCS_OP_RESTORE 4'h1
`define DHCS_OP_READ 4'h2
`define DHCS_OP_WRITE 4'h3
`define DHCS_OP_FORMAT 4'h5
`define DHCS_OP_SEEK 4'h7

`define DHCS_SDH_DRV_MSB 4
`define DHCS_SDH_DRV_LSB 3

`define DHCS_ERR_DAMNF 0
`define DHCS_ERR_TR000 1
`define DHCS_ERR_ABORT 2
`define DHCS_ERR_IDNF 4
`define DHCS_ERR_IDCRC 5
`define DHCS_ERR_UNCORR 6
`define DHCS_ERR_BADBLK 7

`define DHCS_IRQ_DONE 0
`define DHCS_IRQ_ERR 1
`define DHCS_IRQ_CORR 2

`define DHCS_RST_BYTE 8'h00
`define DHCS_RST_IMASK 3'h1
`define DHCS_RST_RATE 4'h0

`define DHCS_N_DRIVES 4
`define DHCS_RESTORE_MAX 11'h400
`define DHCS_CLK_MHZ 40
`define DHCS_STEP_FAST_NS 35000
`define DHCS_STEP_UNIT_NS 500000
`define DHCS_STEP_FAST_CYC ((`DHCS_STEP_FAST_NS*`DHCS_CLK_MHZ+999)/1000)
`define DHCS_STEP_UNIT_CYC (`DHCS_STEP_UNIT_NS*`DHCS_CLK_MHZ/1000)

`endif

// *** include/dhcs_pkg.sv ***
// Types shared by the host command and status block.
// Assumes nothing of its surroundings.
package dhcs_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_STEP,
    S_DISK,
    S_ABORT
  } dhcs_state_e;

  typedef logic [7:0] dhcs_byte_t;
  typedef logic [9:0] dhcs_cyl_t;

endpackage

// *** logic/dhcs_step_gen.sv ***
// Step rate divider: a one-cycle tick every period cycles while run.
// Assumes period is at least one and stays steady while run is high.
`timescale 1ns/1ps
`default_nettype none

module dhcs_step_gen #(
  parameter int PER_W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [PER_W-1:0] period,
  output logic tick
);

  logic [PER_W-1:0] cnt_reg;
  logic [PER_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  if (PER_W < 2)
  begin : g_bad_width
    $error("dhcs_step_gen: PER_W must be at least 2.");
  end

  // Restarting from zero on each run keeps the first step a full period
  // after the command, so a drive never sees a short first gap.
  always_comb
  begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run)
      cnt_next = '0;
    else if (cnt_reg >= PER_W'(period - 1'b1))
    begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
    else
      cnt_next = PER_W'(cnt_reg + 1'b1);
  end

  // Counter and tick registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

// *** logic/dhcs_top.sv ***
// Host command and status block: parameter registers, command start,
// busy, error and corrected flags, head positioning and interrupt.
// Assumes one AHB-Lite master and a disk engine that reports each
// read, write or format command with a one-cycle done pulse.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dhcs_regs.svh"

module dhcs_top #(
  parameter int STEP_UNIT_CYC = `DHCS_STEP_UNIT_CYC,
  parameter int STEP_FAST_CYC = `DHCS_STEP_FAST_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic host_irq_out,
  output logic disk_start,
  output logic [7:0] disk_cmd,
  output logic [7:0] disk_sec,
  output logic [7:0] disk_cnt,
  output logic [9:0] disk_cyl,
  output logic [7:0] disk_sdh,
  output logic [3:0] disk_rate,
  input wire logic disk_done,
  input wire logic disk_fatal,
  input wire logic [6:0] disk_err_hist,
  input wire logic disk_corrected,
  input wire logic track0_in,
  output logic step_out,
  output logic step_dir
);

  localparam int PER_W = 20;

  // A rate unit shorter than the fast period would step faster than 35 us.
  if (STEP_UNIT_CYC < 1 || STEP_FAST_CYC < 1 ||
      STEP_UNIT_CYC < STEP_FAST_CYC ||
      STEP_UNIT_CYC * 15 >= 2 ** PER_W || STEP_FAST_CYC >= 2 ** PER_W)
  begin : g_bad_step
    $error("dhcs_top: step counts do not fit the step divider.");
  end

  dhcs_pkg::dhcs_state_e state_reg, state_next;
  dhcs_pkg::dhcs_byte_t scnt_reg, scnt_next, snum_reg, snum_next;
  dhcs_pkg::dhcs_byte_t cyll_reg, cyll_next, cylh_reg, cylh_next;
  dhcs_pkg::dhcs_byte_t sdh_reg, sdh_next, cmd_reg, cmd_next;
  dhcs_pkg::dhcs_byte_t error_reg, error_next;
  dhcs_pkg::dhcs_cyl_t cur_cyl_reg [`DHCS_N_DRIVES];
  dhcs_pkg::dhcs_cyl_t cur_cyl_next [`DHCS_N_DRIVES];
  dhcs_pkg::dhcs_cyl_t tgt;
  dhcs_pkg::dhcs_cyl_t cur;
  logic busy_reg, busy_next, err_reg, err_next, corr_reg, corr_next;
  logic [3:0] rate_reg, rate_next;
  logic [2:0] istat_reg, istat_next, imask_reg, imask_next;
  logic [2:0] istat_set, istat_clr;
  logic [10:0] steps_reg, steps_next;
  logic [1:0] drv_reg, drv_next;
  logic restore_reg, restore_next;
  logic dir_reg, dir_next, step_reg, step_next;
  logic start_reg, start_next, irq_reg, irq_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_ofs_reg, wr_ofs_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic ready_reg, ready_next;
  logic [7:0] wd, rd_byte, stat_byte, err_onehot;
  logic ap, cmd_go, done, fatal, corr, run, tick;
  logic [PER_W-1:0] step_per;
  logic [PER_W-1:0] gap_reg, gap_next;

  // Fatal outcome: keep only the most severe error of the history.
  function automatic logic [7:0] sev_pick(input logic [6:0] h);
    logic [7:0] r;
    r = 8'h00;
    if (h[0])
      r[`DHCS_ERR_ABORT] = 1'b1;
    else if (h[1])
      r[`DHCS_ERR_TR000] = 1'b1;
    else if (h[2])
      r[`DHCS_ERR_BADBLK] = 1'b1;
    else if (h[3])
      r[`DHCS_ERR_UNCORR] = 1'b1;
    else if (h[4])
      r[`DHCS_ERR_DAMNF] = 1'b1;
    else if (h[5])
      r[`DHCS_ERR_IDCRC] = 1'b1;
    else if (h[6])
      r[`DHCS_ERR_IDNF] = 1'b1;
    else
      r[`DHCS_ERR_ABORT] = 1'b1;
    return r;
  endfunction

  // Bus and command decode terms.
  assign ap = hsel && hready && htrans[1];
  assign wd = hwdata[7:0];
  assign cmd_go = wr_pend_reg && (wr_ofs_reg == `DHCS_OFS_STAT) && !busy_reg;
  assign run = (state_reg == dhcs_pkg::S_STEP);
  assign tgt = {cylh_reg[1:0], cyll_reg};
  assign cur = cur_cyl_reg[sdh_reg[`DHCS_SDH_DRV_MSB:`DHCS_SDH_DRV_LSB]];

  // Rate code zero is the fast rate; other codes are multiples of a unit.
  // R07 fast step rate
  assign step_per = (rate_reg == 4'h0) ? PER_W'(STEP_FAST_CYC) :
                    PER_W'(rate_reg * STEP_UNIT_CYC);

  dhcs_step_gen #(
    .PER_W(PER_W)
  ) u_step (
    .clk(hclk),
    .rst_n(hresetn),
    .run(run),
    .period(step_per),
    .tick(tick)
  );

  // Next values for the bus slave, the registers and the command engine.
  always_comb
  begin
    state_next = state_reg;
    scnt_next = scnt_reg;
    snum_next = snum_reg;
    cyll_next = cyll_reg;
    cylh_next = cylh_reg;
    sdh_next = sdh_reg;
    cmd_next = cmd_reg;
    error_next = error_reg;
    cur_cyl_next = cur_cyl_reg;
    busy_next = busy_reg;
    err_next = err_reg;
    corr_next = corr_reg;
    rate_next = rate_reg;
    imask_next = imask_reg;
    steps_next = steps_reg;
    drv_next = drv_reg;
    restore_next = restore_reg;
    dir_next = dir_reg;
    step_next = 1'b0;
    start_next = 1'b0;
    istat_set = 3'h0;
    istat_clr = 3'h0;
    done = 1'b0;
    fatal = 1'b0;
    corr = 1'b0;
    err_onehot = 8'h00;
    // A write takes one wait state so that a following read sees it.
    ready_next = !(ap && hwrite);
    wr_pend_next = ap && hwrite && (hsize == `DHCS_HSIZE_WORD);
    wr_ofs_next = haddr[7:0];
    stat_byte = 8'h00;
    // R09 busy at bit 7
    stat_byte[`DHCS_ST_BUSY] = busy_reg;
    // R13 error and corrected bits
    stat_byte[`DHCS_ST_ERR] = err_reg;
    stat_byte[`DHCS_ST_CORR] = corr_reg;
    // R03 parameter readback
    case (haddr[7:0])
      `DHCS_OFS_ERROR: rd_byte = error_reg;
      `DHCS_OFS_SCNT: rd_byte = scnt_reg;
      `DHCS_OFS_SNUM: rd_byte = snum_reg;
      `DHCS_OFS_CYLL: rd_byte = cyll_reg;
      `DHCS_OFS_CYLH: rd_byte = cylh_reg;
      `DHCS_OFS_SDH: rd_byte = sdh_reg;
      `DHCS_OFS_STAT: rd_byte = stat_byte;
      `DHCS_OFS_ISTAT: rd_byte = {5'h00, istat_reg};
      `DHCS_OFS_IMASK: rd_byte = {5'h00, imask_reg};
      `DHCS_OFS_RATE: rd_byte = {4'h0, rate_reg};
      default: rd_byte = 8'h00;
    endcase
    hrdata_next = (ap && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    // Register writes land in the first data-phase cycle.
    if (wr_pend_reg)
    begin
      case (wr_ofs_reg)
        `DHCS_OFS_SCNT: scnt_next = wd;
        `DHCS_OFS_SNUM: snum_next = wd;
        `DHCS_OFS_CYLL: cyll_next = wd;
        `DHCS_OFS_CYLH: cylh_next = wd;
        `DHCS_OFS_SDH: sdh_next = wd;
        `DHCS_OFS_ISTAT: istat_clr = wd[2:0];
        `DHCS_OFS_IMASK: imask_next = wd[2:0];
        default: ;
      endcase
    end
    // A command written while busy is dropped; the task file may still
    // be updated so the next command can be prepared early.
    // R16 command start
    if (cmd_go)
    begin
      cmd_next = wd;
      busy_next = 1'b1;
      err_next = 1'b0;
      corr_next = 1'b0;
      error_next = 8'h00;
      istat_clr = 3'h7;
      steps_next = 11'h000;
      drv_next = sdh_reg[`DHCS_SDH_DRV_MSB:`DHCS_SDH_DRV_LSB];
      // R04 keep explicit rate
      unique case (wd[7:4])
        `DHCS_OP_RESTORE:
        begin
          rate_next = wd[3:0];
          restore_next = 1'b1;
          dir_next = 1'b0;
          state_next = dhcs_pkg::S_STEP;
        end
        `DHCS_OP_SEEK:
        begin
          rate_next = wd[3:0];
          restore_next = 1'b0;
          dir_next = (tgt > cur);
          steps_next = (tgt > cur) ? {1'b0, tgt - cur} : {1'b0, cur - tgt};
          state_next = dhcs_pkg::S_STEP;
        end
        `DHCS_OP_READ, `DHCS_OP_WRITE, `DHCS_OP_FORMAT:
        begin
          start_next = 1'b1;
          state_next = dhcs_pkg::S_DISK;
        end
        default: state_next = dhcs_pkg::S_ABORT;
      endcase
    end
    unique case (state_reg)
      dhcs_pkg::S_IDLE: ;
      // R05 no data moved
      dhcs_pkg::S_STEP:
      begin
        if (restore_reg)
        begin
          if (track0_in)
          begin
            done = 1'b1;
            cur_cyl_next[drv_reg] = 10'h000;
          end
          else if (tick && steps_reg == `DHCS_RESTORE_MAX)
          begin
            done = 1'b1;
            fatal = 1'b1;
            err_onehot[`DHCS_ERR_TR000] = 1'b1;
          end
          else if (tick)
          begin
            step_next = 1'b1;
            steps_next = 11'(steps_reg + 1'b1);
          end
        end
        else if (steps_reg == 11'h000)
          done = 1'b1;
        else if (tick)
        begin
          step_next = 1'b1;
          steps_next = 11'(steps_reg - 1'b1);
          cur_cyl_next[drv_reg] = dir_reg ?
            10'(cur_cyl_reg[drv_reg] + 1'b1) :
            10'(cur_cyl_reg[drv_reg] - 1'b1);
        end
      end
      dhcs_pkg::S_DISK:
      begin
        if (disk_done)
        begin
          done = 1'b1;
          fatal = disk_fatal;
          corr = disk_corrected;
          // R15 most severe error
          err_onehot = disk_fatal ? sev_pick(disk_err_hist) : 8'h00;
        end
      end
      dhcs_pkg::S_ABORT:
      begin
        done = 1'b1;
        fatal = 1'b1;
        err_onehot[`DHCS_ERR_ABORT] = 1'b1;
      end
    endcase
    // One completion path for every outcome; only the flags differ.
    // R12 uniform completion
    if (done)
    begin
      state_next = dhcs_pkg::S_IDLE;
      busy_next = 1'b0;
      err_next = fatal;
      // R14 corrected flag
      corr_next = corr;
      // R11 error reg follows flag
      error_next = err_onehot;
      istat_set[`DHCS_IRQ_DONE] = 1'b1;
      istat_set[`DHCS_IRQ_ERR] = fatal;
      istat_set[`DHCS_IRQ_CORR] = corr;
    end
    // Set wins over a clear in the same cycle.
    istat_next = (istat_reg & ~istat_clr) | istat_set;
    // R10 interrupt on completion
    irq_next = |(istat_next & imask_next);
    // Cycles since the last step pulse, held at its top value.
    gap_next = step_reg ? '0 :
               ((&gap_reg) ? gap_reg : PER_W'(gap_reg + 1'b1));
  end

  // All state registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= dhcs_pkg::S_IDLE;
      scnt_reg <= `DHCS_RST_BYTE;
      snum_reg <= `DHCS_RST_BYTE;
      cyll_reg <= `DHCS_RST_BYTE;
      cylh_reg <= `DHCS_RST_BYTE;
      sdh_reg <= `DHCS_RST_BYTE;
      cmd_reg <= `DHCS_RST_BYTE;
      error_reg <= `DHCS_RST_BYTE;
      for (int i = 0; i < `DHCS_N_DRIVES; i++)
        cur_cyl_reg[i] <= 10'h000;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      corr_reg <= 1'b0;
      rate_reg <= `DHCS_RST_RATE;
      istat_reg <= 3'h0;
      imask_reg <= `DHCS_RST_IMASK;
      steps_reg <= 11'h000;
      drv_reg <= 2'h0;
      restore_reg <= 1'b0;
      dir_reg <= 1'b0;
      step_reg <= 1'b0;
      start_reg <= 1'b0;
      irq_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      ready_reg <= 1'b1;
      gap_reg <= '1;
    end
    else
    begin
      state_reg <= state_next;
      scnt_reg <= scnt_next;
      snum_reg <= snum_next;
      cyll_reg <= cyll_next;
      cylh_reg <= cylh_next;
      sdh_reg <= sdh_next;
      cmd_reg <= cmd_next;
      error_reg <= error_next;
      cur_cyl_reg <= cur_cyl_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
      corr_reg <= corr_next;
      rate_reg <= rate_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      steps_reg <= steps_next;
      drv_reg <= drv_next;
      restore_reg <= restore_next;
      dir_reg <= dir_next;
      step_reg <= step_next;
      start_reg <= start_next;
      irq_reg <= irq_next;
      wr_pend_reg <= wr_pend_next;
      wr_ofs_reg <= wr_ofs_next;
      hrdata_reg <= hrdata_next;
      ready_reg <= ready_next;
      gap_reg <= gap_next;
    end
  end

  // Outputs come straight from registers; hresp is tied low.
  assign hrdata = hrdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign host_irq_out = irq_reg;
  assign disk_start = start_reg;
  assign disk_cmd = cmd_reg;
  assign disk_sec = snum_reg;
  assign disk_cnt = scnt_reg;
  assign disk_cyl = {cylh_reg[1:0], cyll_reg};
  assign disk_sdh = sdh_reg;
  assign disk_rate = rate_reg;
  assign step_out = step_reg;
  assign step_dir = dir_reg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_READBACK: assert property ( // R03
    wr_pend_reg && wr_ofs_reg == `DHCS_OFS_SNUM
    |=> snum_reg == $past(hwdata[7:0]))
    else $error("Sector number did not keep the written value.");

  AST_RATE_KEPT: assert property ( // R04
    cmd_go && (wd[7:4] == `DHCS_OP_SEEK || wd[7:4] == `DHCS_OP_RESTORE)
    |=> rate_reg == $past(hwdata[3:0]) && state_reg == dhcs_pkg::S_STEP)
    else $error("Positioning command did not keep its step rate.");

  AST_NO_DATA: assert property ( // R05
    state_reg == dhcs_pkg::S_STEP |-> !disk_start)
    else $error("Disk transfer started during head positioning.");

  AST_STEP_GAP: assert property ( // R07
    step_out |-> gap_reg >= PER_W'(STEP_FAST_CYC - 1))
    else $error("Step pulses closer than the fastest rate.");

  AST_BUSY_SET: assert property ( // R16
    cmd_go |=> busy_reg && !host_irq_out)
    else $error("Command write did not set busy at once.");

  AST_BUSY_CLR: assert property ( // R09
    done |=> !busy_reg && (state_reg == dhcs_pkg::S_IDLE))
    else $error("Busy not cleared on completion.");

  AST_IRQ_RISE: assert property ( // R10
    done && imask_reg[`DHCS_IRQ_DONE] &&
    !(wr_pend_reg && wr_ofs_reg == `DHCS_OFS_IMASK)
    |=> $rose(host_irq_out))
    else $error("Interrupt did not rise on completion.");

  AST_SAME_DONE: assert property ( // R12
    done |=> istat_reg[`DHCS_IRQ_DONE] && err_reg == $past(fatal))
    else $error("Completion differs between error and success.");

  AST_MASK5: assert property ( // R13
    ap && !hwrite && haddr[7:0] == `DHCS_OFS_STAT
    |=> hrdata[0] == $past(err_reg) && hrdata[2] == $past(corr_reg) &&
        hrdata[7] == $past(busy_reg))
    else $error("Status bits not at their places.");

  AST_CORR: assert property ( // R14
    state_reg == dhcs_pkg::S_DISK && disk_done && disk_corrected
    |=> corr_reg)
    else $error("Corrected flag not set.");

  AST_SEVERE: assert property ( // R15
    state_reg == dhcs_pkg::S_DISK && disk_done && disk_fatal &&
    disk_err_hist[1] && !disk_err_hist[0]
    |=> error_reg == 8'h02 && err_reg && !busy_reg)
    else $error("Fatal error not reported as the most severe one.");

endmodule

`default_nettype wire

// *** tb/dhcs_disk_model.sv ***
// Stand-in for the disk engine and the drive behind the command block.
// Assumes one start pulse per disk command and one step pulse per step.
`timescale 1ns/1ps
`default_nettype none

module dhcs_disk_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic disk_start,
  input wire logic step_out,
  input wire logic step_dir,
  input wire logic slow,
  input wire logic fatal_req,
  input wire logic corr_req,
  input wire logic [6:0] hist_req,
  output logic disk_done,
  output logic disk_fatal,
  output logic disk_corrected,
  output logic [6:0] disk_err_hist,
  output logic track0_in,
  output logic [9:0] head_cyl
);
  int wait_cnt;

  // Heads start off cylinder 0, so a restore really has to step.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      head_cyl <= 10'h003;
    end
    else if (step_out === 1'b1)
    begin
      head_cyl <= step_dir ? head_cyl + 10'h001 : head_cyl - 10'h001;
    end
  end
  assign track0_in = (head_cyl == 10'h000);

  // Answers each start promptly or slowly, as the bench asks.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_cnt <= 0;
      disk_done <= 1'b0;
    end
    else
    begin
      disk_done <= (wait_cnt == 1);
      if (disk_start === 1'b1)
      begin
        wait_cnt <= slow ? 40 : 3;
      end
      else if (wait_cnt != 0)
      begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end

  // Qualifiers mean nothing without done; they show the inverse then, so
  // a design that samples them early is caught.
  assign disk_fatal = disk_done ? fatal_req : ~fatal_req;
  assign disk_corrected = disk_done ? corr_req : ~corr_req;
  assign disk_err_hist = disk_done ? hist_req : ~hist_req;
endmodule

`default_nettype wire

// *** tb/disk_ctrl_host_command_status_tb.sv ***
// Self-checking bench of the host command and status block.
// Assumes the block is the only AHB-Lite slave and its disk model.
`timescale 1ns/1ps
`default_nettype none
`include "dhcs_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end

module disk_ctrl_host_command_status_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic fatal_req = 1'b0;
  logic corr_req = 1'b0;
  logic [6:0] hist_req = 7'h00;
  logic [31:0] hrdata;
  logic hreadyout;
  logic host_irq_out;
  logic disk_start;
  logic [7:0] disk_cmd;
  logic hresp;
  logic [7:0] disk_sec;
  logic [7:0] disk_cnt;
  logic [7:0] disk_sdh;
  logic [9:0] disk_cyl;
  logic [3:0] disk_rate;
  logic [7:0] tf[5];
  logic disk_done;
  logic disk_fatal;
  logic disk_corrected;
  logic [6:0] disk_err_hist;
  logic track0_in;
  logic step_out;
  logic step_dir;
  logic [9:0] head_cyl;
  int err_total = 0;
  int n_compared = 0;
  int seed = 12;
  string nm_q[$];
  logic [31:0] exp_q[$];
  logic [7:0] cmd_q[$];
  logic [31:0] rd_seen;
  event rd_ev;
  logic [7:0] ofs[5] = '{`DHCS_OFS_SNUM, `DHCS_OFS_SDH, `DHCS_OFS_CYLL,
                         `DHCS_OFS_CYLH, `DHCS_OFS_SCNT};
  logic [7:0] t_cmd[4] = '{8'h20, 8'h30, 8'h50, 8'hF0};
  logic [6:0] t_hist[4] = '{7'h00, 7'h08, 7'h0A, 7'h00};
  logic [7:0] t_err[4] = '{8'h00, 8'h40, 8'h02, 8'h04};
  logic [7:0] t_st[4] = '{8'h04, 8'h01, 8'h01, 8'h01};

  // Short step periods keep seeks and restores to a few cycles.
  dhcs_top #(.STEP_UNIT_CYC(4), .STEP_FAST_CYC(3)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .host_irq_out(host_irq_out), .disk_start(disk_start),
    .disk_cmd(disk_cmd), .disk_sec(disk_sec), .disk_cnt(disk_cnt),
    .disk_cyl(disk_cyl), .disk_sdh(disk_sdh), .disk_rate(disk_rate),
    .disk_done(disk_done),
    .disk_fatal(disk_fatal), .disk_err_hist(disk_err_hist),
    .disk_corrected(disk_corrected), .track0_in(track0_in),
    .step_out(step_out), .step_dir(step_dir));

  dhcs_disk_model disk_u (
    .hclk(hclk), .hresetn(hresetn), .disk_start(disk_start),
    .step_out(step_out), .step_dir(step_dir), .slow(slow),
    .fatal_req(fatal_req), .corr_req(corr_req), .hist_req(hist_req),
    .disk_done(disk_done), .disk_fatal(disk_fatal),
    .disk_corrected(disk_corrected), .disk_err_hist(disk_err_hist),
    .track0_in(track0_in), .head_cyl(head_cyl));

  // Clock at 40 MHz.
  always #12.5 hclk = ~hclk;

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    results();
  endtask

  // Samples ready mid-cycle, so the edge that follows is the one it counts.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50) timeout();
      @(negedge hclk);
    end
    rd_seen = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `DHCS_HSIZE_WORD;
    haddr <= {24'h000000, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    nm_q.push_back($sformatf("reg %0h", a));
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
    -> rd_ev;
  endtask

  // bounded interrupt wait
  // Waits, bounded, for the interrupt line to go high.
  task automatic wait_irq();
    int n;
    n = 0;
    @(negedge hclk);
    while (host_irq_out !== 1'b1)
    begin
      n++;
      if (n > 5000) timeout();
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  // Each read result is compared against the oldest note.
  initial
  begin : monitor
    string nm;
    logic [31:0] e;
    forever
    begin
      @(rd_ev);
      nm = nm_q.pop_front();
      e = exp_q.pop_front();
      `CHK(nm, e, rd_seen)
    end
  end

  // Every start pulse must match a command the bench sent while idle.
  always @(negedge hclk)
  begin
    if (disk_start === 1'b1)
    begin
      `CHK("disk_cmd", (cmd_q.size() ? cmd_q.pop_front() : 8'hxx), disk_cmd)
      `CHK("disk_sec", tf[0], disk_sec)
      `CHK("disk_sdh", tf[1], disk_sdh)
      `CHK("disk_cnt", tf[4], disk_cnt)
      `CHK("disk_cyl", 10'h002, disk_cyl)
      `CHK("disk_rate", 4'h0, disk_rate)
      `CHK("hresp", 1'b0, hresp)
    end
  end

  initial
  begin : main
    logic [7:0] v;
    int i;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`DHCS_OFS_STAT, 32'h0);
    rd(`DHCS_OFS_IMASK, 32'h1);
    // task file in the usual order, contents read back.
    for (i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      if (i == 3) v = v & 8'h03;
      if (i == 1) v = v & 8'h1F;
      tf[i] = v;
      bus(1'b1, ofs[i], {24'h000000, v});
      rd(ofs[i], {24'h000000, v});
    end
    bus(1'b1, `DHCS_OFS_IMASK, 32'h7);
    // slow restore first, then a fast seek.
    bus(1'b1, `DHCS_OFS_STAT, 32'h11);
    @(negedge hclk);
    `CHK("irq", 1'b0, host_irq_out)
    @(posedge hclk);
    rd(`DHCS_OFS_STAT, 32'h80);
    wait_irq();
    rd(`DHCS_OFS_STAT, 32'h0);
    rd(`DHCS_OFS_ISTAT, 32'h1);
    rd(`DHCS_OFS_RATE, 32'h1);
    `CHK("cyl", 10'h000, head_cyl)
    bus(1'b1, `DHCS_OFS_CYLL, 32'h2);
    bus(1'b1, `DHCS_OFS_CYLH, 32'h0);
    bus(1'b1, `DHCS_OFS_STAT, 32'h70);
    wait_irq();
    rd(`DHCS_OFS_STAT, 32'h0);
    rd(`DHCS_OFS_RATE, 32'h0);
    rd(`DHCS_OFS_DATA, 32'h0);
    `CHK("cyl", 10'h002, head_cyl)
    bus(1'b1, `DHCS_OFS_RATE, 32'h5);
    rd(`DHCS_OFS_RATE, 32'h0);
    // Disk commands with correction, fatal history and a bad opcode.
    for (i = 0; i < 4; i++)
    begin
      slow <= (i == 1);
      fatal_req <= t_st[i][0];
      corr_req <= t_st[i][2];
      hist_req <= t_hist[i];
      if (t_cmd[i][7:4] != 4'hF) cmd_q.push_back(t_cmd[i]);
      bus(1'b1, `DHCS_OFS_STAT, {24'h000000, t_cmd[i]});
      if (i == 1) bus(1'b1, `DHCS_OFS_STAT, 32'h20);
      wait_irq();
      rd(`DHCS_OFS_STAT, {24'h000000, t_st[i]});
      rd(`DHCS_OFS_ISTAT, {29'h0, t_st[i][2], t_st[i][0], 1'b1});
      if (t_st[i][0]) rd(`DHCS_OFS_ERROR, {24'h000000, t_err[i]});
    end
    // Masked completion, then unmask, then clear by writing one.
    bus(1'b1, `DHCS_OFS_IMASK, 32'h0);
    bus(1'b1, `DHCS_OFS_STAT, 32'h70);
    rd(`DHCS_OFS_STAT, 32'h0);
    @(negedge hclk);
    `CHK("irq", 1'b0, host_irq_out)
    @(posedge hclk);
    rd(`DHCS_OFS_ISTAT, 32'h1);
    bus(1'b1, `DHCS_OFS_IMASK, 32'h1);
    rd(`DHCS_OFS_IMASK, 32'h1);
    @(negedge hclk);
    `CHK("irq", 1'b1, host_irq_out)
    @(posedge hclk);
    bus(1'b1, `DHCS_OFS_ISTAT, 32'h1);
    rd(`DHCS_OFS_ISTAT, 32'h0);
    @(negedge hclk);
    `CHK("irq", 1'b0, host_irq_out)
    @(posedge hclk);
    bus(1'b1, 8'h40, 32'hFF);
    rd(8'h40, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK("cmds", 0, cmd_q.size())
    results();
  end
endmodule

`default_nettype wire
